// *** core/mci_pkg.sv ***
package mci_pkg;

  // Frame layout: byte positions of a serial frame; a CAN frame skips the first and last.
  localparam logic [3:0] POS_ADDR   = 4'h0;
  localparam logic [3:0] POS_CMD    = 4'h1;
  localparam logic [3:0] POS_TYPE   = 4'h2;
  localparam logic [3:0] POS_MOTOR  = 4'h3;
  localparam logic [3:0] POS_VAL_HI = 4'h4;
  localparam logic [3:0] POS_VAL_LO = 4'h7;
  localparam logic [3:0] POS_CSUM   = 4'h8;

  // Reply status codes.
  localparam logic [7:0] ST_OK      = 8'h64;
  localparam logic [7:0] ST_STORED  = 8'h65;
  localparam logic [7:0] ST_BAD_SUM = 8'h01;
  localparam logic [7:0] ST_BAD_CMD = 8'h02;
  localparam logic [7:0] ST_BAD_TYP = 8'h03;
  localparam logic [7:0] ST_BAD_VAL = 8'h04;
  localparam logic [7:0] ST_LOCKED  = 8'h05;
  localparam logic [7:0] ST_NO_CMD  = 8'h06;

  // Command numbers.
  localparam logic [7:0] rotate_cw_cmd          = 8'h01;
  localparam logic [7:0] rotate_ccw_cmd         = 8'h02;
  localparam logic [7:0] halt_axis_cmd          = 8'h03;
  localparam logic [7:0] goto_position_cmd      = 8'h04;
  localparam logic [7:0] write_axis_param_cmd   = 8'h05;
  localparam logic [7:0] read_axis_param_cmd    = 8'h06;
  localparam logic [7:0] save_axis_param_cmd    = 8'h07;
  localparam logic [7:0] reload_axis_param_cmd  = 8'h08;
  localparam logic [7:0] write_global_param_cmd = 8'h09;
  localparam logic [7:0] read_global_param_cmd  = 8'h0a;

  // Target kinds of a position move.
  localparam logic [7:0] absolute_target          = 8'h00;
  localparam logic [7:0] relative_target          = 8'h01;
  localparam logic [7:0] stored_coordinate_target = 8'h02;

  // Sizes.
  localparam int unsigned NUM_AXES   = 6;
  localparam int unsigned PROG_DEPTH = 2048;
  localparam int unsigned PROG_AW    = 11;

  // Operation handed to the motion core.
  typedef enum logic [3:0] {
    OP_NONE     = 4'b0000,
    OP_ROT_CW   = 4'b0001,
    OP_ROT_CCW  = 4'b0010,
    OP_HALT     = 4'b0011,
    OP_GOTO     = 4'b0100,
    OP_WR_AXIS  = 4'b0101,
    OP_RD_AXIS  = 4'b0110,
    OP_SAVE_AX  = 4'b0111,
    OP_LOAD_AX  = 4'b1000,
    OP_WR_GLOB  = 4'b1001,
    OP_RD_GLOB  = 4'b1010
  } mci_op_t;

  typedef enum logic [1:0] {
    S_RX    = 2'b00,
    S_EXEC  = 2'b01,
    S_TX    = 2'b10,
    S_DRAIN = 2'b11
  } mci_state_t;

  // One decoded command: number, type, motor or bank, value.
  typedef struct packed {
    logic [7:0]  num;
    logic [7:0]  typ;
    logic [7:0]  motor;
    logic [31:0] value;
  } mci_cmd_t;

  // Answer of the motion core.
  typedef struct packed {
    logic [7:0]  status;
    logic [31:0] result;
  } mci_done_t;

endpackage : mci_pkg

// *** core/mci_buf.sv ***
`timescale 1ns/1ps
module mci_buf #(
  parameter int unsigned WIDTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  empty
);

  typedef struct packed {
    logic             ov;
    logic [WIDTH-1:0] od;
    logic             sv;
    logic [WIDTH-1:0] sd;
  } mci_buf_st_t;

  mci_buf_st_t st;
  mci_buf_st_t next_st;

  assign in_ready  = !st.sv;
  assign out_valid = st.ov;
  assign out_data  = st.od;
  assign empty     = !st.ov && !st.sv;

  ////////////////////////////////////////////////////////////////////////
  // Output stage plus skid entry; a stalled drain parks one word in the skid.
  always_comb begin
    next_st = st;
    if (!st.ov || out_ready) begin
      if (st.sv) begin
        // The producer saw in_ready low this cycle, so its word is not taken here.
        next_st.ov = 1'b1;
        next_st.od = st.sd;
        next_st.sv = 1'b0;
      end else begin
        next_st.ov = in_valid;
        next_st.od = in_data;
      end
    end else if (in_valid && !st.sv) begin
      next_st.sv = 1'b1;
      next_st.sd = in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule : mci_buf

// *** core/mci_core.sv ***
`timescale 1ns/1ps
// What this block does
// - Serial frame: address, command, type, motor, value, checksum.
// - Value bytes travel most significant first.
// - Command checksum is 8-bit sum of eight bytes.
// - Reply: reply address, address, status, command, value, checksum.
// - Reply checksum is 8-bit sum of others.
// - Every reply carries one of the status codes; a nonzero status from the motion core is passed on unchecked.
// - One reply per command, after it completes.
// - Never transmit without a received command.
// - Receive only while no command is in hand; drive bus only while replying.
// - CAN commands drop address and checksum bytes.
// - CAN replies drop reply address and checksum.
// - Commands one to four are motion operations.
// - Commands five to ten are parameter operations.
// - Hold up to 2048 program instructions.
module mci_core
  import mci_pkg::*;
#(
  parameter int unsigned AXES = NUM_AXES
) (
  input  wire logic               SYS_CLK,
  input  wire logic               RST,
  input  wire logic               CAN_MODE,
  input  wire logic [7:0]         MODULE_ADDR,
  input  wire logic [7:0]         REPLY_ADDR,
  input  wire logic               CFG_LOCKED,
  input  wire logic               PROG_LOAD,
  input  wire logic               RX_VALID,
  input  wire logic [7:0]         RX_DATA,
  output logic                    RX_READY,
  output logic                    EXEC_VALID,
  output mci_pkg::mci_op_t        EXEC_OP,
  output mci_pkg::mci_cmd_t       EXEC_CMD,
  input  wire logic               EXEC_DONE,
  input  wire mci_pkg::mci_done_t EXEC_ANSWER,
  output logic                    TX_VALID,
  input  wire logic               TX_READY,
  output logic [7:0]              TX_DATA,
  output logic                    TX_DRIVE,
  input  wire logic [10:0]        PROG_RD_ADDR,
  output mci_pkg::mci_cmd_t       PROG_RD_DATA,
  output logic                    PROG_FULL
);

  import mci_pkg::*;

  typedef struct packed {
    mci_state_t        fsm;
    logic [3:0]        cnt;
    logic [7:0]        sum;
    logic [7:0]        addr;
    mci_cmd_t          cmd;
    mci_op_t           op;
    logic [7:0]        status;
    logic [31:0]       value;
    logic              exec;
    logic              rx_rdy;
    logic              tx_en;
    logic [PROG_AW:0]  wptr;
  } mci_core_st_t;

  mci_core_st_t st;
  mci_core_st_t next_st;
  mci_cmd_t     prog_mem [PROG_DEPTH];
  mci_cmd_t     prog_rd;
  logic         mem_we;
  logic         push;
  logic [7:0]   push_data;
  logic         buf_ready;
  logic         buf_empty;
  logic [3:0]   rx_last;
  logic [3:0]   tx_first;
  logic [3:0]   tx_last;
  logic [3:0]   rx_pos;

  ////////////////////////////////////////////////////////////////////////
  // One reply byte by position; the last position is the wrapping sum of the rest.
  function automatic logic [7:0] reply_byte(input logic [3:0] i, input logic [7:0] ra,
                                            input logic [7:0] ma, input logic [7:0] stt,
                                            input logic [7:0] cm, input logic [31:0] v);
    logic [7:0] s;
    s = 8'h00;
    case (i)
      4'h0: s = ra;
      4'h1: s = ma;
      4'h2: s = stt;
      4'h3: s = cm;
      4'h4: s = v[31:24];
      4'h5: s = v[23:16];
      4'h6: s = v[15:8];
      4'h7: s = v[7:0];
      default: begin
        s = ra + ma + stt + cm + v[31:24] + v[23:16] + v[15:8] + v[7:0];
      end
    endcase
    return s;
  endfunction : reply_byte

  // Decode a command number to an operation; OP_NONE means unknown.
  function automatic mci_op_t decode_op(input logic [7:0] num);
    mci_op_t o;
    o = OP_NONE;
    case (num)
      rotate_cw_cmd:          o = OP_ROT_CW;
      rotate_ccw_cmd:         o = OP_ROT_CCW;
      halt_axis_cmd:          o = OP_HALT;
      goto_position_cmd:      o = OP_GOTO;
      write_axis_param_cmd:   o = OP_WR_AXIS;
      read_axis_param_cmd:    o = OP_RD_AXIS;
      save_axis_param_cmd:    o = OP_SAVE_AX;
      reload_axis_param_cmd:  o = OP_LOAD_AX;
      write_global_param_cmd: o = OP_WR_GLOB;
      read_global_param_cmd:  o = OP_RD_GLOB;
      default:                o = OP_NONE;
    endcase
    return o;
  endfunction : decode_op

  // Check the fields of a decoded command and give the status it earns.
  function automatic logic [7:0] check_cmd(input mci_op_t o, input mci_cmd_t c,
                                           input logic locked);
    logic [7:0] s;
    s = ST_OK;
    if (o == OP_NONE) begin
      s = ST_BAD_CMD;
    end else if (o == OP_GOTO && c.typ > stored_coordinate_target) begin
      s = ST_BAD_TYP;
    end else if (o < OP_WR_GLOB && c.motor >= 8'(AXES)) begin
      s = ST_BAD_VAL;
    end else if (o == OP_SAVE_AX && locked) begin
      s = ST_LOCKED;
    end
    return s;
  endfunction : check_cmd

  ////////////////////////////////////////////////////////////////////////
  // CAN frames carry neither the address byte nor the checksum byte.
  assign rx_last  = CAN_MODE ? POS_VAL_LO : POS_CSUM;
  assign tx_first = CAN_MODE ? POS_CMD : POS_ADDR;
  assign tx_last  = CAN_MODE ? POS_VAL_LO : POS_CSUM;
  // An idle count of zero is read as the command byte in CAN mode, so a frame after
  // reset or after a mode change between frames still lands on the right fields.
  assign rx_pos   = (CAN_MODE && st.cnt == POS_ADDR) ? POS_CMD : st.cnt;

  assign RX_READY   = st.rx_rdy;
  assign EXEC_VALID = st.exec;
  assign EXEC_OP    = st.op;
  assign EXEC_CMD   = st.cmd;
  assign TX_DRIVE   = st.tx_en;
  assign PROG_FULL  = st.wptr[PROG_AW];

  ////////////////////////////////////////////////////////////////////////
  // Frame intake, decision, execution hand-off and reply emission.
  always_comb begin
    next_st   = st;
    next_st.exec = 1'b0;
    mem_we    = 1'b0;
    push      = 1'b0;
    push_data = reply_byte(st.cnt, REPLY_ADDR, MODULE_ADDR, st.status, st.cmd.num,
                           st.value);
    case (st.fsm)
      S_RX: begin
        if (RX_VALID && st.rx_rdy) begin
          next_st.sum = st.sum + RX_DATA;
          case (rx_pos)
            POS_ADDR:  next_st.addr = RX_DATA;
            POS_CMD:   next_st.cmd.num = RX_DATA;
            POS_TYPE:  next_st.cmd.typ = RX_DATA;
            POS_MOTOR: next_st.cmd.motor = RX_DATA;
            POS_CSUM:  next_st.sum = st.sum;
            default:   next_st.cmd.value = {st.cmd.value[23:0], RX_DATA};
          endcase
          if (rx_pos == rx_last) begin
            next_st.sum   = 8'h00;
            next_st.cnt   = tx_first;
            next_st.value = 32'h0000_0000;
            next_st.op    = decode_op(next_st.cmd.num);
            next_st.status = check_cmd(next_st.op, next_st.cmd, CFG_LOCKED);
            if (!CAN_MODE && st.addr != MODULE_ADDR) begin
              next_st.cnt = POS_ADDR;
            end else begin
              next_st.rx_rdy = 1'b0;
              next_st.tx_en  = 1'b1;
              next_st.fsm    = S_TX;
              if (!CAN_MODE && st.sum != RX_DATA) begin
                next_st.status = ST_BAD_SUM;
              end else if (next_st.status == ST_OK && PROG_LOAD) begin
                if (st.wptr[PROG_AW]) begin
                  next_st.status = ST_NO_CMD;
                end else begin
                  mem_we = 1'b1;
                  next_st.wptr = st.wptr + 1'b1;
                  next_st.status = ST_STORED;
                end
              end else if (next_st.status == ST_OK) begin
                next_st.tx_en = 1'b0;
                next_st.exec  = 1'b1;
                next_st.fsm   = S_EXEC;
              end
            end
          end else begin
            next_st.cnt = rx_pos + 4'h1;
          end
        end
      end
      S_EXEC: begin
        // The reply waits for the core to finish the command.
        if (EXEC_DONE) begin
          next_st.status = (EXEC_ANSWER.status == 8'h00) ? ST_OK : EXEC_ANSWER.status;
          next_st.value  = EXEC_ANSWER.result;
          next_st.tx_en  = 1'b1;
          next_st.fsm    = S_TX;
        end
      end
      S_TX: begin
        push = 1'b1;
        if (buf_ready) begin
          if (st.cnt == tx_last) begin
            next_st.fsm = S_DRAIN;
          end else begin
            next_st.cnt = st.cnt + 4'h1;
          end
        end
      end
      S_DRAIN: begin
        // Keep the bus driver on until the last byte has left the buffer.
        if (buf_empty) begin
          next_st.tx_en  = 1'b0;
          next_st.rx_rdy = 1'b1;
          next_st.cnt    = POS_ADDR; // Idle count; rx_pos maps it in CAN mode.
          next_st.fsm    = S_RX;
        end
      end
      default: begin
        next_st.fsm = S_RX;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      st        <= '0;
      st.rx_rdy <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Program store; the read port is registered so it maps onto block memory.
  always_ff @(posedge SYS_CLK) begin
    if (mem_we) begin
      prog_mem[st.wptr[PROG_AW-1:0]] <= next_st.cmd;
    end
    prog_rd <= prog_mem[PROG_RD_ADDR];
  end

  assign PROG_RD_DATA = prog_rd;

  // Two-entry buffer; a stalled receiver holds the reply without losing a byte.
  mci_buf #(
    .WIDTH (8)
  ) u_buf (
    .clk       (SYS_CLK),
    .rst       (RST),
    .in_valid  (push),
    .in_ready  (buf_ready),
    .in_data   (push_data),
    .out_valid (TX_VALID),
    .out_ready (TX_READY),
    .out_data  (TX_DATA),
    .empty     (buf_empty)
  );

  ////////////////////////////////////////////////////////////////////////
  // Checks on the block's own behaviour.
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);

  sequence s_frame_end;
    st.fsm == S_RX && RX_VALID && st.rx_rdy && rx_pos == rx_last;
  endsequence

  sequence s_exec_done;
    st.fsm == S_EXEC && EXEC_DONE;
  endsequence

  a_bus_idle_quiet: assert property (!TX_DRIVE |-> !TX_VALID && buf_empty)
    else $error("Reply byte offered while bus not driven.");

  a_rx_tx_excl: assert property (RX_READY |-> !TX_DRIVE)
    else $error("Receiving and driving at once.");

  a_reply_after_done: assert property (s_exec_done |=> st.fsm == S_TX && TX_DRIVE)
    else $error("Finished command not followed by reply.");

  a_exec_only_ok: assert property (EXEC_VALID
    |-> st.status == ST_OK && st.op != OP_NONE)
    else $error("Command executed despite error status.");

  a_foreign_drop: assert property (s_frame_end
    ##0 (!CAN_MODE && st.addr != MODULE_ADDR)
    |=> RX_READY && !TX_DRIVE && !EXEC_VALID)
    else $error("Foreign frame was answered.");

  a_bad_sum: assert property (s_frame_end
    ##0 (!CAN_MODE && st.addr == MODULE_ADDR && st.sum != RX_DATA)
    |=> st.status == ST_BAD_SUM && !EXEC_VALID)
    else $error("Bad checksum not reported.");

  a_msb_first: assert property (push && buf_ready && st.cnt == POS_VAL_HI
    |-> push_data == st.value[31:24])
    else $error("Value not sent most significant first.");

  a_can_no_sum: assert property (push && buf_ready && CAN_MODE
    |-> st.cnt >= POS_CMD && st.cnt <= POS_VAL_LO)
    else $error("CAN reply carries address or checksum.");

  a_reply_sum: assert property (push && buf_ready && st.cnt == POS_CSUM
    |-> push_data == 8'(REPLY_ADDR + MODULE_ADDR + st.status + st.cmd.num
        + st.value[31:24] + st.value[23:16] + st.value[15:8] + st.value[7:0]))
    else $error("Reply checksum wrong.");

  a_store_101: assert property (mem_we |=> st.status == ST_STORED && !EXEC_VALID)
    else $error("Stored command not acknowledged.");

  a_frame_closes: assert property (s_frame_end
    ##0 (CAN_MODE || st.addr == MODULE_ADDR)
    |=> !RX_READY && (EXEC_VALID || TX_DRIVE))
    else $error("Accepted frame did not close the receiver.");

  a_drive_release: assert property (st.fsm == S_DRAIN && buf_empty
    |=> !TX_DRIVE && RX_READY && st.fsm == S_RX)
    else $error("Bus driver held after the reply left.");

  a_can_cmd_first: assert property (CAN_MODE && RX_VALID && RX_READY
    && st.fsm == S_RX && st.cnt == POS_ADDR |=> EXEC_CMD.num == $past(RX_DATA))
    else $error("CAN frame did not start at the command byte.");

endmodule : mci_core

// *** sim/mci_core_model.sv ***
`timescale 1ns/1ps
module mci_core_model
  import mci_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              exec_valid,
  input  wire mci_pkg::mci_cmd_t exec_cmd,
  input  wire logic [7:0]        delay,
  output logic                   exec_done,
  output mci_pkg::mci_done_t     exec_answer
);
  logic [7:0] cnt;
  logic       busy;

  // One job at a time; the answer is valid only in the done cycle, so it toggles otherwise.
  always_ff @(posedge clk) begin
    if (rst) begin
      busy        <= 1'b0;
      cnt         <= 8'h00;
      exec_done   <= 1'b0;
      exec_answer <= '0;
    end else begin
      exec_done   <= 1'b0;
      exec_answer <= ~exec_answer;
      if (exec_valid) begin
        busy <= 1'b1;
        cnt  <= delay;
      end else if (busy && cnt != 8'h00) begin
        cnt <= cnt - 8'h01;
      end else if (busy) begin
        busy        <= 1'b0;
        exec_done   <= 1'b1;
        exec_answer <= {8'h00, ~exec_cmd.value};
      end
    end
  end
endmodule : mci_core_model

// *** sim/tb_mci_core.sv ***
`timescale 1ns/1ps
module tb_mci_core;
  import mci_pkg::*;
  localparam logic [7:0] MA = 8'h2c;
  localparam logic [7:0] RA = 8'h02;
  logic clk, rst, can_mode, cfg_locked, prog_load, rx_valid, rx_ready;
  logic exec_valid, exec_done, tx_valid, tx_ready, tx_data_drive, prog_full;
  logic [7:0]  rx_data, tx_data, delay;
  logic [10:0] prog_rd_addr;
  mci_op_t     exec_op;
  mci_cmd_t    exec_cmd, prog_rd_data;
  mci_done_t   exec_answer;
  logic [7:0]  frame[$];
  logic [7:0]  rep[$];
  int          num_errors, n_checks, n_exec, n_done;

  mci_core u_dut (.SYS_CLK(clk), .RST(rst), .CAN_MODE(can_mode), .MODULE_ADDR(MA),
    .REPLY_ADDR(RA), .CFG_LOCKED(cfg_locked), .PROG_LOAD(prog_load), .RX_VALID(rx_valid),
    .RX_DATA(rx_data), .RX_READY(rx_ready), .EXEC_VALID(exec_valid), .EXEC_OP(exec_op),
    .EXEC_CMD(exec_cmd), .EXEC_DONE(exec_done), .EXEC_ANSWER(exec_answer),
    .TX_VALID(tx_valid), .TX_READY(tx_ready), .TX_DATA(tx_data), .TX_DRIVE(tx_data_drive),
    .PROG_RD_ADDR(prog_rd_addr), .PROG_RD_DATA(prog_rd_data), .PROG_FULL(prog_full));
  mci_core_model u_core (.clk(clk), .rst(rst), .exec_valid(exec_valid), .exec_cmd(exec_cmd),
    .delay(delay), .exec_done(exec_done), .exec_answer(exec_answer));

  // Free-running 100 MHz clock.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : check8

  task automatic check1(input logic got, input logic exp);
    check8({7'h00, got}, {7'h00, exp});
  endtask : check1

  // Counts hand-overs and answers; a reply byte with the driver off or a job pending is wrong.
  always @(posedge clk) begin
    if (exec_valid === 1'b1) n_exec++;
    if (exec_done === 1'b1) n_done++;
    if (tx_valid === 1'b1) check1(tx_data_drive, 1'b1);
    if (tx_valid === 1'b1) check1(n_exec == n_done, 1'b1);
  end

  task automatic make_frame(input logic [7:0] ma, cm, ty, mo, input logic [31:0] v);
    logic [7:0] s;
    frame = {};
    if (!can_mode) frame.push_back(ma);
    frame.push_back(cm);
    frame.push_back(ty);
    frame.push_back(mo);
    for (int i = 3; i >= 0; i--) frame.push_back(v[i*8 +: 8]);
    s = 8'h00;
    foreach (frame[i]) s += frame[i];
    if (!can_mode) frame.push_back(s);
  endtask : make_frame

  // Host offers the next command only after the reply is complete.
  task automatic send_frame();
    int g;
    @(posedge clk);
    foreach (frame[i]) begin
      rx_valid <= 1'b1;
      rx_data  <= frame[i];
      g = 0;
      do begin
        @(posedge clk);
        g++;
      end while (rx_ready !== 1'b1 && g < 100);
    end
    rx_valid <= 1'b0;
  endtask : send_frame

  // Collects reply bytes while stalling every third cycle.
  task automatic get_reply(input int n);
    int k;
    rep = {};
    k   = 0;
    while (rep.size() < n && k < 400) begin
      @(posedge clk);
      if (tx_valid === 1'b1 && tx_ready === 1'b1) rep.push_back(tx_data);
      tx_ready <= (k % 3 != 2);
      k++;
    end
    tx_ready <= 1'b1;
    check8(rep.size(), n);
    repeat (3) @(posedge clk);
    check1(tx_data_drive, 1'b0);
    check1(rx_ready, 1'b1);
  endtask : get_reply

  task automatic run_cmd(input logic [7:0] cm, ty, mo, input logic [31:0] v,
                         input logic [7:0] st, input bit full);
    int e0, o;
    logic [7:0]  s;
    logic [31:0] ev;
    e0 = n_exec;
    ev = (st == ST_OK) ? ~v : 32'h0;
    make_frame(MA, cm, ty, mo, v);
    send_frame();
    get_reply(can_mode ? 7 : 9);
    if (rep.size() < (can_mode ? 7 : 9)) return;
    o = can_mode ? 0 : 1;
    if (!can_mode) check8(rep[0], RA);
    check8(rep[o], MA);
    check8(rep[o+1], st);
    check8(rep[o+2], cm);
    for (int i = 0; i < 4; i++) if (full) check8(rep[o+3+i], ev[(3-i)*8 +: 8]);
    s = 8'h00;
    for (int i = 0; i < rep.size() - 1; i++) s += rep[i];
    if (!can_mode) check8(rep[8], s);
    check8(n_exec - e0, (st == ST_OK) ? 1 : 0);
    if (st == ST_OK) check8({4'h0, exec_op}, cm);
    if (st == ST_OK) check8(exec_cmd.value[7:0], v[7:0]);
    if (st == ST_OK) check8(exec_cmd.motor, mo);
  endtask : run_cmd

  task automatic t_all_cmds();
    for (int c = 1; c <= 10; c++) begin
      delay <= (c % 2) ? 8'h00 : 8'h14;
      run_cmd(c[7:0], 8'h00, 8'h05, 32'h8123_4500 + c, ST_OK, 1);
    end
    for (int t = 0; t < 3; t++) run_cmd(goto_position_cmd, t[7:0], 8'h00, 32'h10, ST_OK, 1);
  endtask : t_all_cmds

  task automatic t_errors();
    make_frame(MA, rotate_cw_cmd, 8'h00, 8'h01, 32'h55);
    frame[8] = frame[8] + 8'h01;
    send_frame();
    get_reply(9);
    check8(rep[2], ST_BAD_SUM);
    run_cmd(8'h0b, 8'h00, 8'h00, 32'h1, ST_BAD_CMD, 1);
    run_cmd(goto_position_cmd, 8'h03, 8'h00, 32'h1, ST_BAD_TYP, 1);
    run_cmd(rotate_ccw_cmd, 8'h00, 8'h06, 32'h1, ST_BAD_VAL, 1);
    cfg_locked <= 1'b1;
    run_cmd(save_axis_param_cmd, 8'h04, 8'h00, 32'h0, ST_LOCKED, 1);
    cfg_locked <= 1'b0;
  endtask : t_errors

  task automatic t_foreign();
    int e0;
    e0 = n_exec;
    make_frame(MA + 8'h01, halt_axis_cmd, 8'h00, 8'h00, 32'h0);
    send_frame();
    repeat (20) begin
      @(posedge clk);
      check1(tx_data_drive | tx_valid, 1'b0);
    end
    check8(n_exec - e0, 0);
    run_cmd(halt_axis_cmd, 8'h00, 8'h00, 32'h0, ST_OK, 1);
  endtask : t_foreign

  task automatic t_can();
    can_mode <= 1'b1;
    @(posedge clk);
    run_cmd(read_global_param_cmd, 8'h01, 8'h00, 32'hcafe_0001, ST_OK, 1);
    run_cmd(8'h0c, 8'h00, 8'h00, 32'h0, ST_BAD_CMD, 1);
    can_mode <= 1'b0;
    @(posedge clk);
  endtask : t_can

  task automatic t_prog();
    prog_load <= 1'b1;
    run_cmd(halt_axis_cmd, 8'h00, 8'h02, 32'h0000_0777, ST_STORED, 1);
    prog_load    <= 1'b0;
    prog_rd_addr <= 11'h000;
    repeat (3) @(posedge clk);
    check8(prog_rd_data.num, halt_axis_cmd);
    check8(prog_rd_data.value[7:0], 8'h77);
    check1(prog_full, 1'b0);
  endtask : t_prog

  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : print_verdict

  // The whole sequence needs under a thousand cycles; this limit leaves ample margin.
  initial begin
    #300000;
    num_errors++;
    print_verdict();
  end

  // Reset for three cycles, then the scenarios back to back.
  initial begin
    rst = 1'b1; can_mode = 1'b0; cfg_locked = 1'b0; prog_load = 1'b0;
    rx_valid = 1'b0; rx_data = 8'h00; tx_ready = 1'b1; delay = 8'h02;
    prog_rd_addr = 11'h000; num_errors = 0; n_checks = 0; n_exec = 0; n_done = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    check1(tx_data_drive, 1'b0);
    t_all_cmds();
    t_errors();
    t_foreign();
    t_can();
    t_prog();
    print_verdict();
  end
endmodule : tb_mci_core
